// ==== shared/flash_cmd_pkg.sv ====
// constants shared by the flash instruction handler and its host controller
// assumes both ends run on one 20 MHz system clock
package flash_cmd_pkg;
  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
  localparam logic [7:0] OP_MFR_DEVICE_ID = 8'h90;
  localparam logic [7:0] OP_IDENT = 8'h9F;
  // identity bytes, values arbitrary
  localparam logic [7:0] MANUFACTURER_ID = 8'h5A;
  localparam logic [7:0] DEVICE_ID = 8'h13;
  localparam logic [7:0] MEMORY_TYPE = 8'h30;
  localparam logic [7:0] CAPACITY = 8'h14;
  // status byte layout
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LSB = 2;
  localparam int SR_TB = 5;
  // array geometry: 16 blocks of 64K bytes
  localparam int NUM_BLOCKS = 16;
  localparam int BLOCK_LSB = 16;
  // bit counts of instruction frames
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_WITH_ADDR = 6'h20;
  // timing
  localparam int CLK_NS = 50;
  localparam int BLOCK_ERASE_US = 1000;
  localparam int CHIP_ERASE_US = 2000;
  localparam int PD_ENTRY_US = 3;
  localparam int WAKE_RELEASE_US = 3;
  localparam int WAKE_ID_US = 2;
  localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_US * 1000 / CLK_NS;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_US * 1000 / CLK_NS;
  localparam int PD_ENTRY_CYCLES = PD_ENTRY_US * 1000 / CLK_NS;
  localparam int WAKE_RELEASE_CYCLES = (WAKE_RELEASE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_ID_CYCLES = (WAKE_ID_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HOST_HALF_PERIOD = 4'h8;
  localparam logic [3:0] HOST_CS_GAP = 4'h8;
  // host register map
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_ADDRESS = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_READ_DATA = 8'h0C;
  localparam int CMD_ADDR_BYTES_LSB = 8;
  localparam int CMD_READ_BYTES_LSB = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== shared/flash_link_if.sv ====
// serial link between host controller and flash instruction handler
// assumes the bench joins the two ends through one instance
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
  logic chip_select_n;
  logic serial_clock;
  logic serial_data_io;
  logic serial_data_out;
  modport device (
    input chip_select_n,
    input serial_clock,
    input serial_data_io,
    output serial_data_out
  );
  modport host (
    output chip_select_n,
    output serial_clock,
    output serial_data_io,
    input serial_data_out
  );
endinterface
`default_nettype wire

// ==== src/flash_cmd_device.sv ====
// flash instruction handler: erase, power-down, release and id reads
// assumes the link pins come from another domain and are synchronised here
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_device import flash_cmd_pkg::*; #(
  parameter int BLOCK_ERASE_LEN = BLOCK_ERASE_CYCLES,
  parameter int CHIP_ERASE_LEN = CHIP_ERASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  flash_link_if.device link,
  // protection settings
  input wire logic top_bottom_protect_select,
  input wire logic block_protect_bit2,
  input wire logic block_protect_bit1,
  input wire logic block_protect_bit0,
  // state and erase orders
  output logic busy,
  output logic write_enable_latch,
  output logic powered_down,
  output logic erase_start,
  output logic erase_whole_chip,
  output logic [3:0] erase_block
);

  typedef enum logic [4:0] {
    op_none = 5'b00001,
    op_block = 5'b00010,
    op_chip = 5'b00100,
    op_sleep = 5'b01000,
    op_wake = 5'b10000
  } timed_op_type;

  function automatic logic [7:0] resp_byte(input logic [7:0] op, input logic [1:0] idx,
                                           input logic a0, input logic [7:0] status);
    logic [7:0] b;
    b = status;
    unique case (op)
      OP_IDENT: b = (idx == 2'h0) ? MANUFACTURER_ID : (idx == 2'h1) ? MEMORY_TYPE : CAPACITY;
      OP_RELEASE_ID: b = DEVICE_ID;
      OP_MFR_DEVICE_ID: b = (idx[0] ^ a0) ? DEVICE_ID : MANUFACTURER_ID;
      default: b = status;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edges
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic sck_prev;
  logic cs_prev;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      si_sync <= 2'h0;
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], link.chip_select_n};
      sck_sync <= {sck_sync[0], link.serial_clock};
      si_sync <= {si_sync[0], link.serial_data_io};
      sck_prev <= sck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  wire logic sck_rise = sck_sync[1] & ~sck_prev & ~cs_sync[1];
  wire logic sck_fall = ~sck_sync[1] & sck_prev & ~cs_sync[1];
  wire logic frame_end = cs_sync[1] & ~cs_prev;

  ////////////////////////////////////////////////////////////////////////
  // frame reception
  logic [5:0] bit_count;
  logic [31:0] rx;
  logic [7:0] opcode;
  logic addr_lsb;
  logic sending;
  logic [7:0] tx_shift;
  logic [1:0] out_idx;
  logic [2:0] out_bit;
  logic serial_out;
  timed_op_type timed_op;
  logic [23:0] timer;

  wire logic [31:0] next_rx = {rx[30:0], si_sync[1]};
  wire logic [7:0] status_byte = {2'h0, top_bottom_protect_select, block_protect_bit2,
                                  block_protect_bit1, block_protect_bit0,
                                  write_enable_latch, busy};
  wire logic [2:0] bp = {block_protect_bit2, block_protect_bit1, block_protect_bit0};
  wire logic asleep = powered_down;
  wire logic idle_op = (timed_op == op_none);
  wire logic [7:0] rx_op = (bit_count == 6'h07) ? next_rx[7:0] : opcode;
  wire logic resp_allowed = asleep ? (rx_op == OP_RELEASE_ID) :
                            busy ? (rx_op == OP_READ_STATUS) :
                            (rx_op != OP_RELEASE_ID) | idle_op;
  wire logic short_resp = (bit_count == 6'h07) &
                          (next_rx[7:0] == OP_READ_STATUS | next_rx[7:0] == OP_IDENT);
  wire logic long_resp = (bit_count == 6'h1F) &
                         (opcode == OP_RELEASE_ID | opcode == OP_MFR_DEVICE_ID);
  wire logic start_resp = sck_rise & ~sending & resp_allowed & (short_resp | long_resp);

  always_ff @(posedge clk) begin
    if (sys_rst | cs_sync[1]) begin
      bit_count <= 6'h00;
      rx <= 32'h0;
    end else if (sck_rise) begin
      rx <= next_rx;
      bit_count <= (bit_count == 6'h3F) ? bit_count : bit_count + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opcode <= 8'h00;
      addr_lsb <= 1'b0;
    end else if (sck_rise & (bit_count == 6'h07)) begin
      opcode <= next_rx[7:0];
    end else if (sck_rise & (bit_count == 6'h1F)) begin
      addr_lsb <= next_rx[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response shifting on falling edges
  // id bytes out msb first
  always_ff @(posedge clk) begin
    if (sys_rst | cs_sync[1]) begin
      sending <= 1'b0;
      tx_shift <= 8'h00;
      out_idx <= 2'h0;
      out_bit <= 3'h0;
      serial_out <= 1'b0;
    end else if (start_resp) begin
      sending <= 1'b1;
      tx_shift <= resp_byte(rx_op, 2'h0, next_rx[0], status_byte);
      out_idx <= 2'h1;
      out_bit <= 3'h0;
    end else if (sending & sck_fall) begin
      serial_out <= tx_shift[7];
      out_bit <= out_bit + 3'h1;
      if (out_bit == 3'h7) begin
        tx_shift <= resp_byte(opcode, out_idx, addr_lsb, status_byte);
        out_idx <= (opcode == OP_IDENT && out_idx == 2'h2) ? out_idx : out_idx + 2'h1;
      end else begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  assign link.serial_data_out = serial_out;

  ////////////////////////////////////////////////////////////////////////
  // end-of-frame decode
  wire logic [3:0] target_block = rx[BLOCK_LSB +: 4];
  wire logic [5:0] prot_count = (bp == 3'h0) ? 6'h00 : 6'(6'h01 << (bp - 3'h1));
  wire logic block_prot = top_bottom_protect_select ?
                          ({2'h0, target_block} < prot_count) :
                          ({2'h0, target_block} >= 6'(NUM_BLOCKS) - prot_count);
  wire logic awake_free = frame_end & ~asleep & idle_op;
  wire logic go_block = awake_free & (opcode == OP_BLOCK_ERASE) &
                        (bit_count == BITS_WITH_ADDR) & write_enable_latch & ~block_prot;
  wire logic go_chip = awake_free & (opcode == OP_CHIP_ERASE) & (bit_count == BITS_OPCODE) &
                       write_enable_latch & (bp == 3'h0);
  wire logic go_sleep = awake_free & (opcode == OP_POWER_DOWN) & (bit_count == BITS_OPCODE);
  wire logic go_wren = awake_free & (opcode == OP_WRITE_ENABLE) & (bit_count == BITS_OPCODE);
  wire logic wake_bare = frame_end & asleep & idle_op & (opcode == OP_RELEASE_ID) &
                         (bit_count == BITS_OPCODE);
  wire logic wake_id = frame_end & asleep & idle_op & (opcode == OP_RELEASE_ID) &
                       (bit_count >= BITS_WITH_ADDR);
  wire logic timer_done = ~idle_op & (timer == 24'h0);

  ////////////////////////////////////////////////////////////////////////
  // self-timed operations
  // timed erase holds busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timed_op <= op_none;
      timer <= 24'h0;
    end else if (go_block) begin
      timed_op <= op_block;
      timer <= 24'(BLOCK_ERASE_LEN - 1);
    end else if (go_chip) begin
      timed_op <= op_chip;
      timer <= 24'(CHIP_ERASE_LEN - 1);
    end else if (go_sleep) begin
      timed_op <= op_sleep;
      timer <= 24'(PD_ENTRY_CYCLES - 1);
    end else if (wake_bare | wake_id) begin
      timed_op <= op_wake;
      timer <= wake_id ? 24'(WAKE_ID_CYCLES - 1) : 24'(WAKE_RELEASE_CYCLES - 1);
    end else if (timer_done) begin
      timed_op <= op_none;
    end else if (~idle_op) begin
      timer <= timer - 24'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powered_down <= 1'b0;
    end else if (timer_done & (timed_op == op_sleep)) begin
      powered_down <= 1'b1;
    end else if (timer_done & (timed_op == op_wake)) begin
      powered_down <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= go_block | go_chip | (busy & ~timer_done);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_enable_latch <= 1'b0;
    end else if (go_wren) begin
      write_enable_latch <= 1'b1;
    end else if (busy & timer_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      erase_start <= 1'b0;
      erase_whole_chip <= 1'b0;
      erase_block <= 4'h0;
    end else begin
      erase_start <= go_block | go_chip;
      if (go_block | go_chip) begin
        erase_whole_chip <= go_chip;
        erase_block <= target_block;
      end
    end
  end

endmodule // flash_cmd_device
`default_nettype wire

// ==== src/flash_cmd_host.sv ====
// host controller: AXI4-Lite registers in, serial instruction frames out
// assumes software keeps the select-high waits that wake-up needs
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host import flash_cmd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  flash_link_if.host link
);

  typedef enum logic [3:0] {
    h_idle = 4'b0001,
    h_shift = 4'b0010,
    h_tail = 4'b0100,
    h_gap = 4'b1000
  } host_state_type;

  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic w_have;
  logic [23:0] address;
  logic [31:0] read_data;
  host_state_type state;

  wire logic do_write = aw_have & w_have & ~s_axi_bvalid;
  wire logic wr_ok = (aw_addr == REG_COMMAND) | (aw_addr == REG_ADDRESS);
  wire logic launch = do_write & (aw_addr == REG_COMMAND) & (state == h_idle);
  wire logic rd_ok = (s_axi_araddr == REG_COMMAND) | (s_axi_araddr == REG_ADDRESS) |
                     (s_axi_araddr == REG_STATE) | (s_axi_araddr == REG_READ_DATA);
  wire logic [31:0] rd_mux = (s_axi_araddr == REG_ADDRESS) ? {8'h00, address} :
                             (s_axi_araddr == REG_STATE) ? {31'h0, state != h_idle} :
                             (s_axi_araddr == REG_READ_DATA) ? read_data : 32'h0;

  assign s_axi_awready = ~aw_have;
  assign s_axi_wready = ~w_have;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have <= 1'b0;
      aw_addr <= 8'h00;
      w_have <= 1'b0;
      w_data <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      address <= 24'h0;
    end else if (do_write & (aw_addr == REG_ADDRESS) & (s_axi_wstrb != 4'h0)) begin
      address <= w_data[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial frame engine
  logic [1:0] miso_sync;
  logic [31:0] tx;
  logic [6:0] bits_left;
  logic [3:0] div;
  logic cs_n;
  logic sck;
  logic si;
  wire logic half_done = (div == HOST_HALF_PERIOD - 4'h1);
  wire logic [6:0] frame_bits = 7'(({4'h0, w_data[CMD_ADDR_BYTES_LSB +: 2]} +
                                     {3'h0, w_data[CMD_READ_BYTES_LSB +: 3]} + 6'h01) * 8);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miso_sync <= 2'h0;
    end else begin
      miso_sync <= {miso_sync[0], link.serial_data_out};
    end
  end

  // data set up before each rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= h_idle;
      tx <= 32'h0;
      bits_left <= 7'h00;
      div <= 4'h0;
      cs_n <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
      read_data <= 32'h0;
    end else begin
      div <= (state == h_idle || half_done) ? 4'h0 : div + 4'h1;
      unique case (state)
        h_idle: begin
          if (launch) begin
            state <= h_shift;
            tx <= {w_data[7:0], address} << 1;
            si <= w_data[7];
            bits_left <= frame_bits;
            cs_n <= 1'b0;
          end
        end
        h_shift: begin
          if (half_done & ~sck) begin
            sck <= 1'b1;
            read_data <= {read_data[30:0], miso_sync[1]};
          end else if (half_done) begin
            sck <= 1'b0;
            bits_left <= bits_left - 7'h01;
            si <= tx[31];
            tx <= tx << 1;
            if (bits_left == 7'h01) begin
              state <= h_tail;
            end
          end
        end
        h_tail: begin
          if (half_done) begin
            cs_n <= 1'b1;
            state <= h_gap;
          end
        end
        h_gap: begin
          if (div == HOST_CS_GAP - 4'h1) begin
            state <= h_idle;
          end
        end
      endcase
    end
  end

  assign link.chip_select_n = cs_n;
  assign link.serial_clock = sck;
  assign link.serial_data_io = si;

endmodule // flash_cmd_host
`default_nettype wire

// ==== verif/flash_link_properties.sv ====
// checker: link wire and device state relations
// assumes one clock and one reset shared by both ends
`timescale 1ns/1ns
`default_nettype none
module flash_link_properties #(
  parameter int BLOCK_LEN = 2000,
  parameter int CHIP_LEN = 2500
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_io,
  input wire logic serial_data_out,
  // device state
  input wire logic busy,
  input wire logic write_enable_latch,
  input wire logic powered_down,
  input wire logic erase_start,
  input wire logic erase_whole_chip
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] busy_len;
  always_ff @(posedge clk) begin
    if (sys_rst || !busy) busy_len <= 16'h0000;
    else busy_len <= busy_len + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_go;
    erase_start && write_enable_latch && chip_select_n;
  endsequence
  sequence s_run;
    busy [*8];
  endsequence
  property p_erase_go;
    erase_start |-> s_go;
  endproperty
  property p_busy_run;
    erase_start |-> ##[0:2] s_run;
  endproperty
  property p_start_idle;
    erase_start |-> !$past(busy, 2);
  endproperty
  property p_len;
    $fell(busy) |-> (erase_whole_chip ? (busy_len >= CHIP_LEN - 2 && busy_len <= CHIP_LEN + 2)
      : (busy_len >= BLOCK_LEN - 2 && busy_len <= BLOCK_LEN + 2));
  endproperty
  property p_wel_clear;
    $fell(busy) |-> !write_enable_latch;
  endproperty
  property p_pd_quiet;
    powered_down |-> !busy && !erase_start;
  endproperty
  property p_pd_entry;
    $rose(powered_down) |-> chip_select_n && $past(chip_select_n, 8);
  endproperty
  property p_sdo_rest;
    chip_select_n && $past(chip_select_n, 6) |-> !serial_data_out;
  endproperty
  property p_clk_idle;
    chip_select_n |-> !serial_clock;
  endproperty
  property p_data_hold;
    serial_clock && $past(serial_clock) |-> $stable(serial_data_io);
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase without latch or frame end");
  a_busy_run: assert property (p_busy_run) else $error("busy not held after start");
  a_start_idle: assert property (p_start_idle) else $error("erase accepted while busy");
  a_len: assert property (p_len) else $error("erase length wrong");
  a_wel_clear: assert property (p_wel_clear) else $error("latch kept after erase");
  a_pd_quiet: assert property (p_pd_quiet) else $error("activity while powered down");
  a_pd_entry: assert property (p_pd_entry) else $error("power-down inside frame");
  a_sdo_rest: assert property (p_sdo_rest) else $error("output busy outside frame");
  a_clk_idle: assert property (p_clk_idle) else $error("clock high while deselected");
  a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");
endmodule // flash_link_properties
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: axi4-lite orders through host to instruction handler
// assumes shortened erase lengths given below
`timescale 1ns/1ns
`default_nettype none
module tb import flash_cmd_pkg::*;;
  localparam int BLEN = 2000;
  localparam int CLEN = 2500;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, d;
  logic [3:0] s_axi_wstrb = 4'h0, erase_block, last_block;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, last_chip;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic top_bottom_protect_select = 1'b0, block_protect_bit2 = 1'b0;
  logic block_protect_bit1 = 1'b0, block_protect_bit0 = 1'b0;
  logic busy, write_enable_latch, powered_down, erase_start, erase_whole_chip;
  int fail_count = 0, comparisons = 0, seed = 97, starts = 0, i;
  always #25 clk = ~clk;
  flash_link_if link();
  flash_cmd_host i_flash_cmd_host (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link);
  flash_cmd_device #(.BLOCK_ERASE_LEN(BLEN), .CHIP_ERASE_LEN(CLEN)) i_flash_cmd_device (.clk,
    .sys_rst, .link, .top_bottom_protect_select, .block_protect_bit2, .block_protect_bit1,
    .block_protect_bit0, .busy, .write_enable_latch, .powered_down, .erase_start,
    .erase_whole_chip, .erase_block);
  flash_link_properties #(.BLOCK_LEN(BLEN), .CHIP_LEN(CLEN)) i_flash_link_properties (.clk,
    .sys_rst, .chip_select_n(link.chip_select_n), .serial_clock(link.serial_clock),
    .serial_data_io(link.serial_data_io), .serial_data_out(link.serial_data_out), .busy,
    .write_enable_latch, .powered_down, .erase_start, .erase_whole_chip);
  always @(posedge clk) if (erase_start === 1'b1) begin
    starts <= starts + 1;
    last_block <= erase_block;
    last_chip <= erase_whole_chip;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic give_up;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim;
  endtask
  task automatic axi_w(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    if (s_axi_bvalid !== 1'b1) give_up;
    chk_word({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_r(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    if (s_axi_rvalid !== 1'b1) give_up;
    v = s_axi_rdata;
    chk_word({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input logic [7:0] op, input logic [1:0] ab, input logic [2:0] rd,
      input logic [23:0] adr, output logic [31:0] v);
    logic [31:0] st;
    int n;
    axi_w(REG_ADDRESS, {8'h00, adr}, RESP_OKAY);
    axi_w(REG_COMMAND, {17'h0, rd, 2'h0, ab, op}, RESP_OKAY);
    n = 0;
    do begin
      axi_r(REG_STATE, st, RESP_OKAY);
      n++;
    end while (st[0] !== 1'b0 && n < 400);
    if (st[0] !== 1'b0) give_up;
    axi_r(REG_READ_DATA, v, RESP_OKAY);
    v &= (rd > 3'h3) ? 32'hFFFFFFFF : ((32'h1 << (8 * rd)) - 32'h1);
  endtask
  function automatic logic [31:0] exp_id(input logic [7:0] op, input logic a0, input int rd);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < rd; k++) begin
      if (op == OP_IDENT) v = {v[23:0], k == 0 ? MANUFACTURER_ID : (k == 1 ? MEMORY_TYPE : CAPACITY)};
      else if (op == OP_MFR_DEVICE_ID) v = {v[23:0], ((k + a0) % 2 == 0) ? MANUFACTURER_ID : DEVICE_ID};
      else v = {v[23:0], DEVICE_ID};
    end
    return v;
  endfunction
  task automatic erase(input logic [7:0] op, input logic [1:0] ab, input logic [2:0] rd,
      input logic [23:0] adr, input logic wren, input int go);
    logic [31:0] v;
    int n0, n;
    if (wren) run(OP_WRITE_ENABLE, 2'h0, 3'h0, 24'h0, v);
    chk_flag(write_enable_latch, wren);
    n0 = starts;
    run(op, ab, rd, adr, v);
    for (n = 0; n < 20 && starts == n0; n++) @(posedge clk);
    chk_word(starts - n0, go);
    if (go != 0) begin
      chk_flag(last_chip, op == OP_CHIP_ERASE);
      if (op == OP_BLOCK_ERASE) chk_word({28'h0, last_block}, {28'h0, adr[19:16]});
      run(OP_READ_STATUS, 2'h0, 3'h1, 24'h0, v);
      chk_word(v, {26'h0, top_bottom_protect_select, block_protect_bit2, block_protect_bit1,
        block_protect_bit0, 2'h3});
      run(OP_RELEASE_ID, 2'h3, 3'h4, 24'h0, v);
      chk_word(v, 32'h0);
      for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
      if (busy !== 1'b0) give_up;
      chk_flag(write_enable_latch, 1'b0);
    end
  endtask
  task automatic wait_pd(input logic lvl);
    for (int n = 0; n < 200 && powered_down !== lvl; n++) @(posedge clk);
    chk_flag(powered_down, lvl);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_word({29'h0, busy, write_enable_latch, powered_down}, 32'h0);
    axi_r(8'h10, d, RESP_SLVERR);
    chk_word(d, 32'h0);
    axi_w(8'h20, 32'h0, RESP_SLVERR);
    run(OP_IDENT, 2'h0, 3'h3, 24'h0, d);
    chk_word(d, exp_id(OP_IDENT, 1'b0, 3));
    for (i = 0; i < 4; i++) begin
      run(OP_MFR_DEVICE_ID, 2'h3, 3'h4, {23'h0, i[0]}, d);
      chk_word(d, exp_id(OP_MFR_DEVICE_ID, i[0], 4));
    end
    r = $random(seed);
    run(OP_RELEASE_ID, 2'h3, 3'h4, r[23:0], d);
    chk_word(d, exp_id(OP_RELEASE_ID, 1'b0, 4));
    $display("id reads done");
    erase(OP_BLOCK_ERASE, 2'h3, 3'h0, r[23:0], 1'b0, 0);
    erase(OP_BLOCK_ERASE, 2'h2, 3'h0, r[23:0], 1'b1, 0);
    erase(OP_BLOCK_ERASE, 2'h3, 3'h1, r[23:0], 1'b1, 0);
    erase(OP_CHIP_ERASE, 2'h1, 3'h0, 24'h0, 1'b1, 0);
    block_protect_bit0 <= 1'b1;
    @(posedge clk);
    erase(OP_BLOCK_ERASE, 2'h3, 3'h0, {4'h0, 4'hF, r[15:0]}, 1'b1, 0);
    erase(OP_BLOCK_ERASE, 2'h3, 3'h0, {4'h0, r[19:16] == 4'hF ? 4'hE : r[19:16], r[15:0]}, 1'b1, 1);
    top_bottom_protect_select <= 1'b1;
    @(posedge clk);
    erase(OP_BLOCK_ERASE, 2'h3, 3'h0, {8'h00, r[15:0]}, 1'b1, 0);
    top_bottom_protect_select <= r[0];
    block_protect_bit2 <= r[1];
    @(posedge clk);
    erase(OP_CHIP_ERASE, 2'h0, 3'h0, 24'h0, 1'b1, 0);
    top_bottom_protect_select <= 1'b0;
    {block_protect_bit2, block_protect_bit0} <= 2'h0;
    @(posedge clk);
    erase(OP_CHIP_ERASE, 2'h0, 3'h0, 24'h0, 1'b1, 1);
    $display("erase done");
    run(OP_POWER_DOWN, 2'h1, 3'h0, 24'h0, d);
    repeat (100) @(posedge clk);
    chk_flag(powered_down, 1'b0);
    run(OP_POWER_DOWN, 2'h0, 3'h0, 24'h0, d);
    wait_pd(1'b1);
    run(OP_IDENT, 2'h0, 3'h3, 24'h0, d);
    chk_word(d, 32'h0);
    run(OP_WRITE_ENABLE, 2'h0, 3'h0, 24'h0, d);
    chk_flag(write_enable_latch, 1'b0);
    run(OP_RELEASE_ID, 2'h0, 3'h0, 24'h0, d);
    wait_pd(1'b0);
    run(OP_POWER_DOWN, 2'h0, 3'h0, 24'h0, d);
    wait_pd(1'b1);
    run(OP_RELEASE_ID, 2'h3, 3'h2, r[23:0], d);
    chk_word(d, exp_id(OP_RELEASE_ID, 1'b0, 2));
    wait_pd(1'b0);
    $display("power-down done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
